//--- design/iotp_pkg.sv
// Package: register map, field layouts and reset values of the oscillator tuner
package iotp_pkg;

  localparam logic [3:0] IOTP_OFS_TUNING  = 4'h0;
  localparam logic [3:0] IOTP_OFS_CONTROL = 4'h4;
  localparam logic [3:0] IOTP_OFS_STATUS  = 4'h8;

  localparam int IOTP_SRC_BIT  = 7;
  localparam int IOTP_PLL_BIT  = 6;
  localparam int IOTP_TRIM_LSB = 0;
  localparam int IOTP_TRIM_W   = 6;

  localparam logic [7:0] IOTP_TUNING_RST = 8'h00;
  localparam logic [2:0] IOTP_FSEL_RST   = 3'h3;
  localparam logic       IOTP_MSEL_RST   = 1'b0;

  // Frequency select codes
  localparam logic [2:0] IOTP_F16M  = 3'h7;
  localparam logic [2:0] IOTP_F8M   = 3'h6;
  localparam logic [2:0] IOTP_F4M   = 3'h5;
  localparam logic [2:0] IOTP_F2M   = 3'h4;
  localparam logic [2:0] IOTP_F1M   = 3'h3;
  localparam logic [2:0] IOTP_F500K = 3'h2;
  localparam logic [2:0] IOTP_F250K = 3'h1;
  localparam logic [2:0] IOTP_F31K  = 3'h0;

  localparam int IOTP_HF_DIV_W = 9;
  localparam int IOTP_MF_DIV_W = 4;

  typedef struct packed {
    logic                   low_freq_source_select;
    logic                   pll_soft_enable;
    logic [IOTP_TRIM_W-1:0] freq_trim;
  } iotp_tuning_type;

  typedef struct packed {
    logic       medium_osc_select;
    logic [2:0] internal_freq_select;
  } iotp_control_type;

  typedef enum logic [2:0] {
    IOTP_SRC_HF = 3'b001,
    IOTP_SRC_MF = 3'b010,
    IOTP_SRC_LF = 3'b100
  } iotp_src_type;

endpackage

//--- design/iotp_top.sv
// Oscillator tuning, internal clock selection and multiplier enable block
`timescale 1ns/10ps
`default_nettype none

module iotp_top
  import iotp_pkg::*;
(
  input  wire logic        clk_i,
  input  wire logic        sys_rst_i,
  input  wire logic [3:0]  avs_address_i,
  input  wire logic        avs_read_i,
  input  wire logic        avs_write_i,
  input  wire logic [31:0] avs_writedata_i,
  output logic      [31:0] avs_readdata_o,
  output logic             avs_waitrequest_o,
  input  wire logic        high_freq_internal_osc_i,
  input  wire logic        medium_freq_internal_osc_i,
  input  wire logic        low_freq_internal_osc_i,
  input  wire logic        pll_config_enable_i,
  input  wire logic        ext_osc_mode_i,
  output logic      [5:0]  freq_trim_o,
  output logic             pll_enable_o,
  output logic             low_freq_source_select_o,
  output logic             medium_osc_select_o,
  output logic      [2:0]  internal_freq_select_o,
  output logic             internal_clock_output_o,
  output logic             lf_timer_clk_o,
  output logic             lf_primary_clk_o
);

  iotp_tuning_type  tuning_q;
  iotp_control_type control_q;
  logic             wait_q;
  logic [31:0]      rdata_q;
  logic [2:0]       hf_sync_q;
  logic [2:0]       mf_sync_q;
  logic [1:0]       lf_sync_q;
  logic [IOTP_HF_DIV_W-1:0] hf_div_q;
  logic [IOTP_MF_DIV_W-1:0] mf_div_q;
  logic             int_clk_q;
  logic             int_clk_d;
  logic             pll_q;
  logic             pll_d;
  logic             lf_tmr_q;
  logic             lf_pri_q;
  iotp_src_type     src_d;
  logic             acc;
  logic             wr_en;

  assign acc   = (avs_read_i | avs_write_i) & wait_q;
  assign wr_en = avs_write_i & ~wait_q;

  function automatic logic [31:0] iotp_rd(input logic [3:0] a,
                                          input iotp_tuning_type t,
                                          input iotp_control_type c,
                                          input logic p,
                                          input iotp_src_type s);
    logic [31:0] r;
    r = 32'h0000_0000;
    case (a)
      IOTP_OFS_TUNING:  r = {24'h00_0000, t};
      IOTP_OFS_CONTROL: r = {28'h000_0000, c};
      IOTP_OFS_STATUS:  r = {28'h000_0000, s, p};
      default:          r = 32'h0000_0000;
    endcase
    return r;
  endfunction

  // One wait cycle per access, fixed; a trim write never holds the bus longer
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      wait_q  <= 1'b1;
      rdata_q <= 32'h0000_0000;
    end else if (acc) begin
      wait_q  <= 1'b0;
      rdata_q <= iotp_rd(avs_address_i, tuning_q, control_q, pll_q, src_d);
    end else begin
      wait_q  <= 1'b1;
    end
  end

  // Tuning register: source select, soft PLL enable, signed trim
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      tuning_q <= IOTP_TUNING_RST;
    end else if (wr_en && avs_address_i == IOTP_OFS_TUNING) begin
      tuning_q.low_freq_source_select <= avs_writedata_i[IOTP_SRC_BIT];
      tuning_q.pll_soft_enable        <= avs_writedata_i[IOTP_PLL_BIT];
      tuning_q.freq_trim <=
        avs_writedata_i[IOTP_TRIM_LSB +: IOTP_TRIM_W];
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      control_q.internal_freq_select <= IOTP_FSEL_RST;
      control_q.medium_osc_select    <= IOTP_MSEL_RST;
    end else if (wr_en && avs_address_i == IOTP_OFS_CONTROL) begin
      control_q <= avs_writedata_i[3:0];
    end
  end

  // Oscillator pins are foreign to clk_i; two stages before any edge logic
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hf_sync_q <= 3'h0;
      mf_sync_q <= 3'h0;
      lf_sync_q <= 2'h0;
    end else begin
      hf_sync_q <= {hf_sync_q[1:0], high_freq_internal_osc_i};
      mf_sync_q <= {mf_sync_q[1:0], medium_freq_internal_osc_i};
      lf_sync_q <= {lf_sync_q[0], low_freq_internal_osc_i};
    end
  end

  // Ripple-free dividers counting oscillator rising edges
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      hf_div_q <= '0;
      mf_div_q <= '0;
    end else begin
      if (hf_sync_q[1] & ~hf_sync_q[2]) begin
        hf_div_q <= hf_div_q + 1'b1;
      end
      if (mf_sync_q[1] & ~mf_sync_q[2]) begin
        mf_div_q <= mf_div_q + 1'b1;
      end
    end
  end

  // Source used for the selected rate
  always_comb begin
    src_d = IOTP_SRC_HF;
    case (control_q.internal_freq_select)
      IOTP_F500K,
      IOTP_F250K: begin
        src_d = control_q.medium_osc_select ? IOTP_SRC_MF
                                            : IOTP_SRC_HF;
      end
      IOTP_F31K: begin
        if (!tuning_q.low_freq_source_select) begin
          src_d = IOTP_SRC_LF;
        end else if (control_q.medium_osc_select) begin
          src_d = IOTP_SRC_MF;
        end else begin
          src_d = IOTP_SRC_HF;
        end
      end
      default: src_d = IOTP_SRC_HF;
    endcase
  end

  // Divided taps: HF bit n is 16 MHz / 2^(n+1), MF bit n is 500 kHz / 2^(n+1)
  always_comb begin
    int_clk_d = hf_sync_q[1];
    case (control_q.internal_freq_select)
      IOTP_F16M:  int_clk_d = hf_sync_q[1];
      IOTP_F8M:   int_clk_d = hf_div_q[0];
      IOTP_F4M:   int_clk_d = hf_div_q[1];
      IOTP_F2M:   int_clk_d = hf_div_q[2];
      IOTP_F1M:   int_clk_d = hf_div_q[3];
      IOTP_F500K: begin
        int_clk_d = (src_d == IOTP_SRC_MF) ? mf_sync_q[1] : hf_div_q[4];
      end
      IOTP_F250K: begin
        int_clk_d = (src_d == IOTP_SRC_MF) ? mf_div_q[0] : hf_div_q[5];
      end
      IOTP_F31K: begin
        case (src_d)
          IOTP_SRC_LF: int_clk_d = lf_sync_q[1];
          IOTP_SRC_MF: int_clk_d = mf_div_q[3];
          IOTP_SRC_HF: int_clk_d = hf_div_q[8];
          default:     int_clk_d = lf_sync_q[1];
        endcase
      end
      default: int_clk_d = hf_div_q[3];
    endcase
  end

  // Config bit only counts in external modes
  always_comb begin
    if (ext_osc_mode_i) begin
      pll_d = pll_config_enable_i | tuning_q.pll_soft_enable;
    end else begin
      pll_d = tuning_q.pll_soft_enable;
    end
  end

  // The analog multiplier does the x4; this block only gates it, so the
  // input range check stays with software
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      pll_q <= 1'b0;
    end else begin
      pll_q <= pll_d;
    end
  end

  always_ff @(posedge clk_i) begin
    if (sys_rst_i) begin
      int_clk_q <= 1'b0;
      lf_tmr_q  <= 1'b0;
      lf_pri_q  <= 1'b0;
    end else begin
      int_clk_q <= int_clk_d;
      lf_tmr_q  <= lf_sync_q[1];
      lf_pri_q  <= lf_sync_q[1];
    end
  end

  // Trim reaches only the HF/MF analog trim; oscillators slew on their own
  assign freq_trim_o              = tuning_q.freq_trim;
  assign pll_enable_o             = pll_q;
  assign low_freq_source_select_o = tuning_q.low_freq_source_select;
  assign medium_osc_select_o      = control_q.medium_osc_select;
  assign internal_freq_select_o   = control_q.internal_freq_select;
  assign internal_clock_output_o  = int_clk_q;
  assign lf_timer_clk_o           = lf_tmr_q;
  assign lf_primary_clk_o         = lf_pri_q;
  assign avs_readdata_o           = rdata_q;
  assign avs_waitrequest_o        = wait_q;

endmodule

`default_nettype wire

//--- testbench/iotp_top_assertions.sv
// Concurrent checks on the oscillator tuner ports
`timescale 1ns/10ps
`default_nettype none
module iotp_top_assertions
  import iotp_pkg::*;
(
  input wire logic        clk_i,
  input wire logic        sys_rst_i,
  input wire logic [3:0]  avs_address_i,
  input wire logic        avs_read_i,
  input wire logic        avs_write_i,
  input wire logic [31:0] avs_writedata_i,
  input wire logic        avs_waitrequest_o,
  input wire logic        low_freq_internal_osc_i,
  input wire logic        pll_config_enable_i,
  input wire logic        ext_osc_mode_i,
  input wire logic [5:0]  freq_trim_o,
  input wire logic        pll_enable_o,
  input wire logic        low_freq_source_select_o,
  input wire logic        medium_osc_select_o,
  input wire logic [2:0]  internal_freq_select_o,
  input wire logic        lf_timer_clk_o,
  input wire logic        lf_primary_clk_o
);
  logic wr0, wr4, soft_q;
  assign wr0 = avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h0;
  assign wr4 = avs_write_i && !avs_waitrequest_o && avs_address_i == 4'h4;
  // Mirror of the soft enable, since the port only shows the merged enable
  always_ff @(posedge clk_i) begin
    if (sys_rst_i) soft_q <= 1'b0;
    else if (wr0) soft_q <= avs_writedata_i[IOTP_PLL_BIT];
  end
  default clocking cb @(posedge clk_i); endclocking
  default disable iff (sys_rst_i);
  property p_trim; wr0 |=> freq_trim_o == $past(avs_writedata_i[5:0]);
  endproperty
  a_trim: assert property (p_trim) else $error("trim mismatch");
  property p_src; wr0 |=>
    low_freq_source_select_o == $past(avs_writedata_i[7]); endproperty
  a_src: assert property (p_src) else $error("source select mismatch");
  property p_ctl; wr4 |=> internal_freq_select_o == $past(avs_writedata_i[2:0])
    && medium_osc_select_o == $past(avs_writedata_i[3]); endproperty
  a_ctl: assert property (p_ctl) else $error("control mismatch");
  property p_pint; $past(!sys_rst_i) && !$past(ext_osc_mode_i) |->
    pll_enable_o == $past(soft_q); endproperty
  a_pint: assert property (p_pint) else $error("internal pll enable");
  property p_pext; $past(!sys_rst_i) && $past(ext_osc_mode_i) |->
    pll_enable_o == $past(soft_q | pll_config_enable_i); endproperty
  a_pext: assert property (p_pext) else $error("external pll enable");
  property p_rst; $fell(sys_rst_i) |-> internal_freq_select_o == IOTP_F1M;
  endproperty
  a_rst: assert property (p_rst) else $error("reset frequency");
  property p_take; $rose(avs_read_i || avs_write_i) |=> !avs_waitrequest_o;
  endproperty
  a_take: assert property (p_take) else $error("no answer");
  property p_wait; !avs_waitrequest_o |=> avs_waitrequest_o; endproperty
  a_wait: assert property (p_wait) else $error("wait low too long");
  property p_lf; $rose(lf_timer_clk_o) |-> lf_primary_clk_o &&
    $past(low_freq_internal_osc_i, 3); endproperty
  a_lf: assert property (p_lf) else $error("low clock routing");
endmodule
bind iotp_top iotp_top_assertions u_chk (.clk_i, .sys_rst_i, .avs_address_i,
  .avs_read_i, .avs_write_i, .avs_writedata_i, .avs_waitrequest_o,
  .low_freq_internal_osc_i, .pll_config_enable_i, .ext_osc_mode_i,
  .freq_trim_o, .pll_enable_o, .low_freq_source_select_o,
  .medium_osc_select_o, .internal_freq_select_o, .lf_timer_clk_o,
  .lf_primary_clk_o);
`default_nettype wire

//--- testbench/iotp_top_tb.sv
// Self-checking bench for the oscillator tuner
`timescale 1ns/10ps
`default_nettype none
module iotp_top_tb
  import iotp_pkg::*;
;
  logic clk_i = 0, sys_rst_i = 1, avs_read_i = 0, avs_write_i = 0;
  logic [3:0] avs_address_i = '0;
  logic [31:0] avs_writedata_i = '0, avs_readdata_o, v;
  logic high_freq_internal_osc_i = 0, medium_freq_internal_osc_i = 0;
  logic low_freq_internal_osc_i = 0, pll_config_enable_i = 0;
  logic ext_osc_mode_i = 0, avs_waitrequest_o, pll_enable_o;
  logic low_freq_source_select_o, medium_osc_select_o;
  logic internal_clock_output_o, lf_timer_clk_o, lf_primary_clk_o;
  logic [5:0] freq_trim_o;
  logic [2:0] internal_freq_select_o;
  logic [31:0] expq[$];
  int n_fail = 0, checks_done = 0, cyc = 0, tog;
  localparam logic [5:0] TC [4] = '{6'h00, 6'h1f, 6'h20, 6'h3f};
  iotp_top uut (.clk_i, .sys_rst_i, .avs_address_i, .avs_read_i,
    .avs_write_i, .avs_writedata_i, .avs_readdata_o, .avs_waitrequest_o,
    .high_freq_internal_osc_i, .medium_freq_internal_osc_i,
    .low_freq_internal_osc_i, .pll_config_enable_i, .ext_osc_mode_i,
    .freq_trim_o, .pll_enable_o, .low_freq_source_select_o,
    .medium_osc_select_o, .internal_freq_select_o, .internal_clock_output_o,
    .lf_timer_clk_o, .lf_primary_clk_o);
  always #10 clk_i = ~clk_i;
  // Oscillators are slowed to rates the 50 MHz sampler can resolve
  always @(posedge clk_i) begin
    cyc <= cyc + 1;
    high_freq_internal_osc_i <= ~high_freq_internal_osc_i;
    if (cyc % 4 == 0)
      medium_freq_internal_osc_i <= ~medium_freq_internal_osc_i;
    if (cyc % 40 == 0) low_freq_internal_osc_i <= ~low_freq_internal_osc_i;
  end
  task automatic check(input logic [31:0] seen, input logic [31:0] exp);
    checks_done++;
    if (seen !== exp) begin
      n_fail++;
      $display("ERROR t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask
  task automatic bus(input logic w, input logic [3:0] a,
                     input logic [31:0] d, input logic [31:0] e);
    @(posedge clk_i);
    avs_address_i <= a;
    avs_write_i <= w;
    avs_read_i <= !w;
    avs_writedata_i <= d;
    if (!w) expq.push_back(e);
    do @(posedge clk_i); while (avs_waitrequest_o !== 1'b0);
    avs_write_i <= 1'b0;
    avs_read_i <= 1'b0;
  endtask
  task automatic count(input int n);
    logic last;
    tog = 0;
    last = internal_clock_output_o;
    repeat (n) begin
      @(posedge clk_i);
      if (internal_clock_output_o !== last) tog++;
      last = internal_clock_output_o;
    end
  endtask
  task automatic print_verdict();
    if (n_fail == 0 && checks_done > 0) $display("STATUS OK");
    else $display("STATUS NOT OK");
    $finish;
  endtask
  always @(posedge clk_i)
    if (avs_read_i && avs_waitrequest_o === 1'b0 && expq.size() > 0)
      check(avs_readdata_o, expq.pop_front());
  initial begin
    repeat (20000) @(posedge clk_i);
    n_fail++;
    print_verdict();
  end
  initial begin
    v = $urandom(32'he134);
    repeat (12) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    bus(0, IOTP_OFS_TUNING, '0, {24'h0, IOTP_TUNING_RST});
    bus(0, IOTP_OFS_CONTROL, '0, {28'h0, IOTP_MSEL_RST, IOTP_FSEL_RST});
    for (int i = 0; i < 4; i++) begin
      v = $urandom;
      v[5:0] = TC[i];
      bus(1, IOTP_OFS_TUNING, v, '0);
      bus(0, IOTP_OFS_TUNING, '0, {24'h0, v[7:0]});
      check({26'h0, freq_trim_o}, {26'h0, v[5:0]});
    end
    for (int i = 0; i < 8; i++) begin
      v = $urandom;
      v[2:0] = i[2:0];
      bus(1, IOTP_OFS_CONTROL, v, '0);
      bus(0, IOTP_OFS_CONTROL, '0, {28'h0, v[3:0]});
    end
    // The status word is read-only, and a stray address must not alias
    bus(1, IOTP_OFS_STATUS, 32'hffff_ffff, '0);
    bus(1, 4'hc, 32'hffff_ffff, '0);
    bus(0, 4'hc, '0, '0);
    // Every mix of external mode, config bit and soft enable, checked on the PLL enable
    for (int i = 0; i < 8; i++) begin
      ext_osc_mode_i <= i[2];
      pll_config_enable_i <= i[1];
      bus(1, IOTP_OFS_TUNING, {25'h0, i[0], 6'h0}, '0);
      repeat (3) @(posedge clk_i);
      check(pll_enable_o, i[0] | (i[2] & i[1]));
    end
    bus(0, IOTP_OFS_STATUS, '0, {28'h0, 3'b001, 1'b1});
    bus(1, IOTP_OFS_CONTROL, {29'h0, IOTP_F16M}, '0);
    count(64);
    check(tog > 16, 1);
    bus(1, IOTP_OFS_CONTROL, {29'h0, IOTP_F31K}, '0);
    count(240);
    check(tog > 3 && tog < 9, 1);
    bus(0, IOTP_OFS_STATUS, '0, {28'h0, 3'b100, 1'b1});
    sys_rst_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    sys_rst_i <= 1'b0;
    bus(0, IOTP_OFS_CONTROL, '0, {28'h0, IOTP_MSEL_RST, IOTP_FSEL_RST});
    repeat (2) @(posedge clk_i);
    print_verdict();
  end
endmodule
`default_nettype wire
